// *** core/vme_top.sv ***
// write-only mode-control register bank of the video encoder, reached by
// sub-address over the two-wire serial bus, plus the decode of its fields.
// assumes the bus wire is resolved outside from o_sda and o_sda_oe_n.
//
// Function
// - registers writable, never read back
// - primary bit 7 picks pin or register mode
// - primary bit 6 selects chroma number format
// - primary bit 5 puts converters to sleep
// - primary bit 4 rgb only in listed modes
// - register mode field replaces the mode pins
// - codes for the 525-line standard
// - codes for 625-line standard, 1111 invalid
// - register never selects full logic sleep
// - secondary bit 7 black setup, 525 only
// - secondary bit 6 accepts non-standard line counts
// - secondary bit 5 picks rgb input range
// - full sleep only from pins, ycbcr, 1111
// - rgb needs pin, qualifying code, register bit
module vme_top #(
  parameter logic [6:0] DEV_ADDR = vme_pkg::DEV_ADDR_DEFAULT
) (
  input  wire logic       i_sys_clk,       // 250 MHz system clock
  input  wire logic       i_nrst,          // async reset, active low
  input  wire logic       i_scl,           // serial bus clock pin
  input  wire logic       i_sda,           // serial bus data pin level
  output logic            o_sda,           // data driven, always low
  output logic            o_sda_oe_n,      // data enable, low = drive
  input  wire logic [3:0] i_mode_pins,     // external video mode pins
  input  wire logic       i_input_colour_space_select, // 1 = rgb pin
  output logic [3:0]      o_video_mode,    // effective mode code
  output logic            o_std_625,       // 625-line standard
  output logic            o_serial_656,    // embedded-sync input
  output logic            o_mode_invalid,  // register code 1111
  output logic            o_chroma_twos,   // chroma is two's complement
  output logic            o_dac_sleep,     // converters asleep
  output logic            o_logic_sleep,   // full sleep
  output logic            o_rgb_input,     // rgb input active
  output logic            o_black_setup,   // 7.5 ire setup active
  output logic            o_nonstd_lines,  // non-standard line counts ok
  output logic            o_rgb_limited,   // rgb range 16..235
  output logic [4:0]      o_secondary_low  // remaining secondary bits
);

  // ---------------------------------------------------------------
  // reset release and input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  logic [6:0] pins_s;
  logic       scl;
  logic       sda;
  logic [3:0] pin_mode;
  logic       pin_rgb;

  vme_sync #(
    .W (7)
  ) u_sync (
    .i_clk   (i_sys_clk),
    .i_rst_n (rst_n),
    .i_d     ({i_scl, i_sda, i_mode_pins, i_input_colour_space_select}),
    .o_q     (pins_s)
  );

  assign scl      = pins_s[6];
  assign sda      = pins_s[5];
  assign pin_mode = pins_s[4:1];
  assign pin_rgb  = pins_s[0];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    vme_pkg::vme_bus_st_t state;
    logic [3:0]           bitcnt;
    logic [7:0]           shreg;
    logic [7:0]           sub;
    logic                 scl_q;
    logic                 sda_q;
    logic                 sda_oe_n;
    logic [7:0]           primary;
    logic [7:0]           secondary;
    logic [3:0]           video_mode;
    logic                 std_625;
    logic                 serial_656;
    logic                 mode_invalid;
    logic                 chroma_twos;
    logic                 dac_sleep;
    logic                 logic_sleep;
    logic                 rgb_input;
    logic                 black_setup;
    logic                 nonstd_lines;
    logic                 rgb_limited;
  } vme_top_st_t;

  vme_top_st_t st_reg;
  vme_top_st_t st_next;

  always_comb begin
    logic       scl_rise;
    logic       scl_fall;
    logic       start;
    logic       stop;
    logic       done;
    logic [3:0] mode;
    logic       qual;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start    = 1'b0;
    stop     = 1'b0;
    done     = 1'b0;
    mode     = 4'h0;
    qual     = 1'b0;
    st_next  = st_reg;

    // -------------------------------------------------------------
    // bus slave: start/stop detection on synchronised pins only
    // -------------------------------------------------------------
    scl_rise = scl & ~st_reg.scl_q;
    scl_fall = ~scl & st_reg.scl_q;
    start    = st_reg.scl_q & scl & st_reg.sda_q & ~sda;
    stop     = st_reg.scl_q & scl & ~st_reg.sda_q & sda;
    done     = scl_fall && (st_reg.bitcnt == vme_pkg::BITS_PER_BYTE);
    st_next.scl_q = scl;
    st_next.sda_q = sda;

    if (start) begin
      st_next.state    = vme_pkg::ST_ADDR;
      st_next.bitcnt   = vme_pkg::BITCNT_RESET;
      st_next.sda_oe_n = 1'b1;
    end else if (stop) begin
      st_next.state    = vme_pkg::ST_IDLE;
      st_next.sda_oe_n = 1'b1;
    end else begin
      case (st_reg.state)
        vme_pkg::ST_IDLE: begin
          st_next.sda_oe_n = 1'b1;
        end
        vme_pkg::ST_ADDR, vme_pkg::ST_SUB, vme_pkg::ST_DATA: begin
          if (scl_rise && st_reg.bitcnt != vme_pkg::BITS_PER_BYTE) begin
            st_next.shreg  = {st_reg.shreg[6:0], sda};
            st_next.bitcnt = st_reg.bitcnt + 4'h1;
          end else if (done) begin
            st_next.sda_oe_n = 1'b0;
            if (st_reg.state == vme_pkg::ST_ADDR) begin
              // a read request is left unanswered: nothing reads back
              if (st_reg.shreg[7:1] == DEV_ADDR && !st_reg.shreg[0]) begin
                st_next.state = vme_pkg::ST_ACK_ADDR;
              end else begin
                st_next.state    = vme_pkg::ST_IDLE;
                st_next.sda_oe_n = 1'b1;
              end
            end else if (st_reg.state == vme_pkg::ST_SUB) begin
              st_next.sub   = st_reg.shreg;
              st_next.state = vme_pkg::ST_ACK_SUB;
            end else begin
              if (st_reg.sub == vme_pkg::OFS_MODE_CONTROL_PRIMARY) begin
                st_next.primary = st_reg.shreg;
              end
              if (st_reg.sub == vme_pkg::OFS_MODE_CONTROL_SECONDARY) begin
                st_next.secondary = st_reg.shreg;
              end
              // auto-increment lets one burst load both registers
              st_next.sub   = st_reg.sub + 8'h01;
              st_next.state = vme_pkg::ST_ACK_DATA;
            end
          end
        end
        vme_pkg::ST_ACK_ADDR, vme_pkg::ST_ACK_SUB,
        vme_pkg::ST_ACK_DATA: begin
          if (scl_fall) begin
            st_next.sda_oe_n = 1'b1;
            st_next.bitcnt   = vme_pkg::BITCNT_RESET;
            st_next.state    = (st_reg.state == vme_pkg::ST_ACK_ADDR) ?
                               vme_pkg::ST_SUB : vme_pkg::ST_DATA;
          end
        end
        default: begin
          st_next.state    = vme_pkg::ST_IDLE;
          st_next.sda_oe_n = 1'b1;
        end
      endcase
    end

    // -------------------------------------------------------------
    // field decode, registered so every output leaves a flip-flop
    // -------------------------------------------------------------
    mode = st_reg.primary[vme_pkg::P_OVERRIDE] ?
           st_reg.primary[vme_pkg::P_MODE_MSB:0] : pin_mode;
    case (mode)
      vme_pkg::MODE_525_13M5, vme_pkg::MODE_525_12M27,
      vme_pkg::MODE_525_14M32, vme_pkg::MODE_625_13M5,
      vme_pkg::MODE_625_14M75: qual = 1'b1;
      default:                 qual = 1'b0;
    endcase
    st_next.video_mode   = mode;
    st_next.std_625      = mode[vme_pkg::P_STD_625];
    st_next.serial_656   = (mode == vme_pkg::MODE_525_656) ||
                           (mode == vme_pkg::MODE_625_656);
    // 1111 from the register is flagged only, never turned into sleep
    st_next.mode_invalid = st_reg.primary[vme_pkg::P_OVERRIDE] &&
                           (mode == vme_pkg::MODE_SLEEP_OR_BAD);
    st_next.chroma_twos  = st_reg.primary[vme_pkg::P_CHROMA_TWOS];
    st_next.logic_sleep  = !st_reg.primary[vme_pkg::P_OVERRIDE] &&
                           !pin_rgb &&
                           (pin_mode == vme_pkg::MODE_SLEEP_OR_BAD);
    st_next.dac_sleep    = st_reg.primary[vme_pkg::P_DAC_SLEEP] ||
                           st_next.logic_sleep;
    st_next.rgb_input    = pin_rgb && qual &&
                           st_reg.primary[vme_pkg::P_RGB_SELECT];
    st_next.black_setup  = st_reg.secondary[vme_pkg::P_BLACK_SETUP] &&
                           !mode[vme_pkg::P_STD_625];
    st_next.nonstd_lines = st_reg.secondary[vme_pkg::P_NONSTD_LINES];
    st_next.rgb_limited  = st_next.rgb_input &&
                           st_reg.secondary[vme_pkg::P_RGB_RANGE];
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg           <= '0;
      st_reg.state     <= vme_pkg::ST_IDLE;
      st_reg.scl_q     <= 1'b1;
      st_reg.sda_q     <= 1'b1;
      st_reg.sda_oe_n  <= 1'b1;
      // mode 0000 applies in reset, so its decode must say embedded sync
      st_reg.serial_656 <= 1'b1;
      st_reg.primary   <= vme_pkg::RST_MODE_CONTROL_PRIMARY;
      st_reg.secondary <= vme_pkg::RST_MODE_CONTROL_SECONDARY;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_sda           = 1'b0;
  assign o_sda_oe_n      = st_reg.sda_oe_n;
  assign o_video_mode    = st_reg.video_mode;
  assign o_std_625       = st_reg.std_625;
  assign o_serial_656    = st_reg.serial_656;
  assign o_mode_invalid  = st_reg.mode_invalid;
  assign o_chroma_twos   = st_reg.chroma_twos;
  assign o_dac_sleep     = st_reg.dac_sleep;
  assign o_logic_sleep   = st_reg.logic_sleep;
  assign o_rgb_input     = st_reg.rgb_input;
  assign o_black_setup   = st_reg.black_setup;
  assign o_nonstd_lines  = st_reg.nonstd_lines;
  assign o_rgb_limited   = st_reg.rgb_limited;
  assign o_secondary_low = st_reg.secondary[4:0];

endmodule : vme_top

// *** core/vme_pkg.sv ***
// constants and types shared by the video encoder mode-register bank.
// assumes a single 250 MHz system clock domain.
package vme_pkg;

  // ---------------------------------------------------------------
  // register map (sub-addresses on the two-wire bus)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MODE_CONTROL_PRIMARY   = 8'h00;
  localparam logic [7:0] OFS_MODE_CONTROL_SECONDARY = 8'h01;
  localparam logic [7:0] RST_MODE_CONTROL_PRIMARY   = 8'h00;
  localparam logic [7:0] RST_MODE_CONTROL_SECONDARY = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int P_OVERRIDE     = 7;
  localparam int P_CHROMA_TWOS  = 6;
  localparam int P_DAC_SLEEP    = 5;
  localparam int P_RGB_SELECT   = 4;
  localparam int P_MODE_MSB     = 3;
  localparam int P_BLACK_SETUP  = 7;
  localparam int P_NONSTD_LINES = 6;
  localparam int P_RGB_RANGE    = 5;
  localparam int P_STD_625      = 3;

  // ---------------------------------------------------------------
  // video mode codes
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_525_656      = 4'h0;
  localparam logic [3:0] MODE_525_27M      = 4'h1;
  localparam logic [3:0] MODE_525_SQUARE   = 4'h2;
  localparam logic [3:0] MODE_525_4FSC     = 4'h3;
  localparam logic [3:0] MODE_525_13M5     = 4'h5;
  localparam logic [3:0] MODE_525_12M27    = 4'h6;
  localparam logic [3:0] MODE_525_14M32    = 4'h7;
  localparam logic [3:0] MODE_625_656      = 4'h8;
  localparam logic [3:0] MODE_625_27M      = 4'h9;
  localparam logic [3:0] MODE_625_SQUARE   = 4'hA;
  localparam logic [3:0] MODE_625_13M5     = 4'hD;
  localparam logic [3:0] MODE_625_14M75    = 4'hE;
  localparam logic [3:0] MODE_SLEEP_OR_BAD = 4'hF;

  // ---------------------------------------------------------------
  // serial bus
  // ---------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h40;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
  localparam logic [3:0] BITCNT_RESET     = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_SUB, ST_ACK_SUB, ST_DATA, ST_ACK_DATA
  } vme_bus_st_t;

endpackage : vme_pkg

// *** core/vme_sync.sv ***
// two-flop synchroniser for asynchronous inputs, W bits wide.
// assumes an active-low reset already released in the clock domain.
module vme_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,   // destination clock
  input  wire logic         i_rst_n, // synchronised reset, active low
  input  wire logic [W-1:0] i_d,     // asynchronous input
  output logic      [W-1:0] o_q      // synchronised output
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } vme_sync_st_t;

  vme_sync_st_t st_reg;
  vme_sync_st_t st_next;

  always_comb begin
    st_next.meta   = i_d;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_q = st_reg.stable;

endmodule : vme_sync

// *** test/vme_top_monitor.sv ***
// checker for the decoded mode outputs and the ack driver.
// assumes it is bound to vme_top and sees only its ports.
module vme_top_monitor (
  input wire logic       i_sys_clk,      // system clock
  input wire logic       i_nrst,         // async reset, active low
  input wire logic       i_scl,          // bus clock pin
  input wire logic       o_sda_oe_n,     // ack enable, low = drive
  input wire logic [3:0] o_video_mode,   // effective mode code
  input wire logic       o_std_625,      // 625-line standard
  input wire logic       o_serial_656,   // embedded-sync input
  input wire logic       o_mode_invalid, // register code 1111
  input wire logic       o_dac_sleep,    // converters asleep
  input wire logic       o_logic_sleep,  // full sleep
  input wire logic       o_rgb_input,    // rgb input active
  input wire logic       o_black_setup,  // setup active
  input wire logic       o_rgb_limited   // rgb range select
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // relations between outputs
  // ---------------------------------------------------------------
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  chk_rgb_mode_list: assert property (o_rgb_input |->
    o_video_mode inside {4'h5, 4'h6, 4'h7, 4'hD, 4'hE})
    else $error("rgb input outside pixel-rate modes");
  chk_full_sleep_code: assert property (o_logic_sleep |->
    o_video_mode == 4'hF && !o_rgb_input && o_dac_sleep)
    else $error("full sleep without pin code 1111");
  chk_reg_no_sleep: assert property (o_mode_invalid |->
    !o_logic_sleep && o_video_mode == 4'hF)
    else $error("register code caused full sleep");
  chk_std_bit: assert property (o_std_625 == o_video_mode[3])
    else $error("standard flag disagrees with mode");
  chk_656_codes: assert property (
    o_serial_656 == (o_video_mode[2:0] == 3'h0))
    else $error("embedded-sync flag disagrees with mode");
  chk_black_525: assert property (o_black_setup |-> !o_std_625)
    else $error("black setup in 625-line standard");
  chk_range_gate: assert property (o_rgb_limited |-> o_rgb_input)
    else $error("rgb range without rgb input");
  chk_ack_scl_low: assert property ($fell(o_sda_oe_n) |-> !i_scl)
    else $error("ack started while bus clock high");
  chk_ack_bounded: assert property (
    $fell(o_sda_oe_n) |-> ##[1:40] o_sda_oe_n)
    else $error("ack held too long");
  // the first edge of power-up reset still sees flops before the clear
  chk_reset_zero: assert property (disable iff (1'b0)
    !i_nrst ##1 !i_nrst |-> o_sda_oe_n && o_video_mode == 4'h0 &&
    !o_dac_sleep)
    else $error("outputs not cleared in reset");
endmodule : vme_top_monitor

// *** test/vme_host_model.sv ***
// two-wire bus host that writes the mode registers.
// assumes a pull-up wire: releasing data reads back as 1.
module vme_host_model #(
  parameter int H = 4
) (
  input  wire logic i_clk, // system clock
  input  wire logic i_sda, // resolved data wire
  output logic      o_scl, // bus clock, high only when idle or in bits
  output logic      o_sda  // 0 = pull low, 1 = release
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // bit and frame tasks
  // ---------------------------------------------------------------
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc
  task automatic put_bit(input logic b, output logic s);
    cyc(H);
    o_sda = b;
    cyc(H);
    o_scl = 1'b1;
    cyc(H);
    s = i_sda;
    cyc(H);
    o_scl = 1'b0;
  endtask : put_bit
  task automatic put_byte(input logic [7:0] v, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i], s);
    end
    put_bit(1'b1, s);
    ok = ok & !s;
  endtask : put_byte
  // refused frames still run to the stop, as a real host would
  task automatic write(input logic [7:0] dev, sub, d0, d1,
                       output logic ok);
    ok = 1'b1;
    o_sda = 1'b0;
    cyc(H);
    o_scl = 1'b0;
    put_byte(dev, ok);
    put_byte(sub, ok);
    put_byte(d0, ok);
    put_byte(d1, ok);
    cyc(H);
    o_sda = 1'b0;
    cyc(H);
    o_scl = 1'b1;
    cyc(H);
    o_sda = 1'b1;
    cyc(4 * H);
  endtask : write
endmodule : vme_host_model

// *** test/vme_top_tb_top.sv ***
// self-checking bench for the mode-register bank.
// assumes vme_host_model drives the bus; pins driven on falling edges.
module vme_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // bench signals
  // ---------------------------------------------------------------
  logic i_sys_clk = 1'b0, i_nrst = 1'b0, i_scl, i_sda, sda_h, ok;
  logic o_sda, o_sda_oe_n, o_std_625, o_serial_656, o_mode_invalid;
  logic o_chroma_twos, o_dac_sleep, o_logic_sleep, o_rgb_input;
  logic o_black_setup, o_nonstd_lines, o_rgb_limited;
  logic i_input_colour_space_select = 1'b0;
  logic [3:0] i_mode_pins = 4'h0, o_video_mode, c;
  logic [4:0] o_secondary_low;
  int error_cnt = 0, checks = 0, cycles = 0;
  logic [3:0] rgb_codes [7] = '{4'h4, 4'h1, 4'h5, 4'h6, 4'h7, 4'hD, 4'hE};

  assign i_sda = sda_h & (o_sda_oe_n | o_sda);
  always #2 i_sys_clk = ~i_sys_clk;
  vme_top dut_u (.*);
  vme_host_model host_u (.i_clk(i_sys_clk), .i_sda(i_sda),
                         .o_scl(i_scl), .o_sda(sda_h));

  task automatic check(input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic settle(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : settle
  task automatic wr(input logic [7:0] sub, d0, d1);
    host_u.write(8'h80, sub, d0, d1, ok);
    check({7'h0, ok}, 8'h01);
    settle(4);
  endtask : wr

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    check({o_video_mode, o_serial_656, o_dac_sleep, o_rgb_input,
           o_sda_oe_n}, 8'h09);
    check({o_chroma_twos, o_nonstd_lines, o_black_setup,
           o_secondary_low}, 8'h00);
  endtask : t_reset
  task automatic t_pins;
    i_mode_pins = 4'hF;
    settle(8);
    check({o_logic_sleep, o_dac_sleep, o_video_mode, o_mode_invalid,
           o_rgb_input}, 8'hFC);
    i_input_colour_space_select = 1'b1;
    settle(8);
    check({o_logic_sleep, o_dac_sleep, o_video_mode, 2'h0}, 8'h3C);
    i_mode_pins = 4'h5;
    settle(8);
    check({7'h0, o_rgb_input}, 8'h00);
    i_input_colour_space_select = 1'b0;
    i_mode_pins = 4'hF;
  endtask : t_pins
  // pins hold the sleep code so a register override must win
  task automatic t_codes;
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      wr(8'h00, {4'h8, c}, 8'h00);
      check({o_video_mode, o_std_625, o_serial_656, o_mode_invalid,
             o_logic_sleep}, {c, c[3], c[2:0] == 3'h0, c == 4'hF,
             1'b0});
    end
  endtask : t_codes
  task automatic t_rgb;
    i_input_colour_space_select = 1'b1;
    foreach (rgb_codes[i]) begin
      c = rgb_codes[i];
      wr(8'h00, {4'hF, c}, 8'h60);
      check({o_rgb_input, o_rgb_limited, o_chroma_twos, o_dac_sleep,
             o_nonstd_lines, 3'h0}, {{2{i > 1}}, 6'h38});
    end
    i_input_colour_space_select = 1'b0;
    settle(8);
    check({o_rgb_input, o_rgb_limited, 6'h0}, 8'h00);
  endtask : t_rgb
  task automatic t_black;
    wr(8'h00, 8'h81, 8'h9F);
    check({o_black_setup, o_secondary_low, 2'h0}, 8'hFC);
    wr(8'h00, 8'h89, 8'h80);
    check({o_black_setup, o_secondary_low, 2'h0}, 8'h00);
  endtask : t_black
  task automatic t_refuse;
    host_u.write(8'h82, 8'h00, 8'h81, 8'hFF, ok);
    check({7'h0, ok}, 8'h00);
    host_u.write(8'h81, 8'h00, 8'h81, 8'hFF, ok);
    check({7'h0, ok}, 8'h00);
    wr(8'h02, 8'h81, 8'hFF);
    check({o_video_mode, o_black_setup, 3'h0}, 8'h90);
  endtask : t_refuse

  initial begin
    settle(2);
    i_nrst = 1'b1;
    settle(16);
    t_reset();
    t_pins();
    t_codes();
    t_rgb();
    t_black();
    t_refuse();
    // pins back to 0000 so the reset check sees only register defaults
    i_mode_pins = 4'h0;
    i_nrst = 1'b0;
    settle(2);
    i_nrst = 1'b1;
    settle(16);
    t_reset();
    stop_test();
  end
endmodule : vme_top_tb_top

bind vme_top vme_top_monitor mon_u (.*);
